// ==== include/mcc_map.vh ====
`ifndef MCC_MAP_VH
`define MCC_MAP_VH
// Address fields.
`define MCC_ADDR_W        32
`define MCC_OFS_W         14
`define MCC_MOD_LSB       14
`define MCC_MOD_MSB       17
`define MCC_MOD_W         4
`define MCC_MOD_ZERO      4'h0
// Preferential area: block start bits K, low bits L.
`define MCC_PSA_L_W       9
`define MCC_PSA_K_W       5
// Preferential register layout.
`define MCC_PSR_MOD_LSB   0
`define MCC_PSR_ALT_LSB   4
`define MCC_PSR_K_LSB     8
`define MCC_PSR_KEY_LSB   16
`define MCC_PSR_ALTEN_BIT 20
// Comm/state register layout (processor).
`define MCC_CS_MEM_LSB    0
`define MCC_CS_TXP_LSB    15
`define MCC_CS_RXP_LSB    19
`define MCC_CS_TXC_LSB    23
`define MCC_CS_RXC_LSB    26
`define MCC_CS_EN_W       29
`define MCC_CS_ST_LSB     29
`define MCC_CS_ST_W       3
`define MCC_MEM_CS_W      9
`define MCC_IOC_CS_W      21
// State codes.
`define MCC_ST0           3'h0
`define MCC_ST1           3'h1
`define MCC_ST2           3'h2
`define MCC_ST3           3'h6
// Load inhibit bits.
`define MCC_INH_TR1       0
`define MCC_INH_TR2       1
`define MCC_INH_PSR       2
`define MCC_INH_ST        3
`define MCC_INH_EN        4
`define MCC_INH_W         5
`define MCC_SEL_W         22
// Protection word.
`define MCC_PW_KEY_LSB    0
`define MCC_PW_WP_BIT     4
`define MCC_PW_RP_BIT     5
`define MCC_PW_W          6
`define MCC_PW_AW         5
`define MCC_PW_DEPTH      32
`endif

// ==== logic/mcc_key_store.v ====
`timescale 1ns/100ps
`include "mcc_map.vh"
// Small store of protection words with registered read data.
module mcc_key_store (
  // Clock.
  input  wire                    i_clk_sys,
  // Write port.
  input  wire                    i_we,
  input  wire [`MCC_PW_AW-1:0]   i_waddr,
  input  wire [`MCC_PW_W-1:0]    i_wdata,
  // Read port.
  input  wire [`MCC_PW_AW-1:0]   i_raddr,
  output reg  [`MCC_PW_W-1:0]    o_rdata
);
  // Storage array; no reset, software establishes the words.
  reg [`MCC_PW_W-1:0] mem [0:`MCC_PW_DEPTH-1];

  // Write and registered read.
  always @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

// ==== logic/mcc_translate.v ====
`timescale 1ns/100ps
`include "mcc_map.vh"
// Logical to physical translation for one requester.
module mcc_translate #(
  parameter HAS_PSA = 1
) (
  // Logical address.
  input  wire [`MCC_ADDR_W-1:0]  i_laddr,
  // Translation tables, fifteen nibbles in all, entry 1 in the low nibble.
  input  wire [`MCC_ADDR_W-1:0]  i_tr_first,
  input  wire [`MCC_ADDR_W-1:0]  i_tr_second,
  input  wire [`MCC_ADDR_W-1:0]  i_psr,
  // Result.
  output reg  [`MCC_ADDR_W-1:0]  o_paddr,
  output reg  [`MCC_MOD_W-1:0]   o_alt_mod,
  output reg                     o_invalid
);
  // Combinational translation; entries 1..7 in the first, 8..15 second.
  reg [`MCC_MOD_W-1:0] lmod;
  reg [`MCC_MOD_W-1:0] pmod;
  always @* begin
    lmod      = i_laddr[`MCC_MOD_MSB:`MCC_MOD_LSB];
    pmod      = `MCC_MOD_ZERO;
    o_paddr   = {`MCC_ADDR_W{1'b0}};
    o_alt_mod = `MCC_MOD_ZERO;
    o_invalid = 1'b0;
    if (lmod != `MCC_MOD_ZERO) begin
      // Table entry gated to the module select.
      if (lmod < 4'h8) begin
        pmod = i_tr_first[(lmod-4'h1)*4 +: 4];
      end else begin
        pmod = i_tr_second[(lmod-4'h8)*4 +: 4];
      end
      // Offset passes unchanged.
      o_paddr[`MCC_OFS_W-1:0] = i_laddr[`MCC_OFS_W-1:0];
      o_paddr[`MCC_MOD_MSB:`MCC_MOD_LSB] = pmod;
    end else if (HAS_PSA != 0) begin
      // Module and K from the register, L from the address.
      o_paddr[`MCC_PSA_L_W-1:0] = i_laddr[`MCC_PSA_L_W-1:0];
      o_paddr[`MCC_OFS_W-1:`MCC_PSA_L_W] =
        i_psr[`MCC_PSR_K_LSB +: `MCC_PSA_K_W];
      o_paddr[`MCC_MOD_MSB:`MCC_MOD_LSB] =
        i_psr[`MCC_PSR_MOD_LSB +: `MCC_MOD_W];
      if (i_psr[`MCC_PSR_ALTEN_BIT]) begin
        o_alt_mod = i_psr[`MCC_PSR_ALT_LSB +: `MCC_MOD_W];
      end
      // Overflow past the block is flagged invalid.
      o_invalid = (i_laddr[`MCC_OFS_W-1:`MCC_PSA_L_W] != 5'h00);
    end else begin
      // Controllers have no preferential path.
      o_invalid = 1'b1;
    end
    // Upper bits must be zero.
    if (i_laddr[`MCC_ADDR_W-1:`MCC_MOD_MSB+1] != 14'h0000) begin
      o_invalid = 1'b1;
    end
  end
endmodule

// ==== logic/mcc_config_control.v ====
`timescale 1ns/100ps
`include "mcc_map.vh"
// Functional notes
// - nonzero module field uses translation entry
// - zero module selects preferential area module
// - 4-bit module field, offset passes through
// - preferential address from stored module and K
// - controller translation has no preferential path
// - access needs table, own and module enables
// - processor enables split transmit and receive
// - controller and memory enable field widths
// - register widths 32, 9 and 21 bits
// - state codes 000, 001, 010, 110
// - state 1 finishes operation then halts
// - other state 3 halts and blocks us
// - controllers stop at once in state 3
// - state 3 enables external load only
// - state 3 reaches all non-isolated modules
// - leaving state 3 resumes or refetches
// - self load anytime, external needs state 3
// - self load four words, five inhibits
// - external load selects by 22 bits
// - memory reads six-bit protection word
// - key mismatch blocks protected read or write
// - requester key held in preferential register
//
// One processor's configuration control, with the memory-side and
// controller-side control registers it may load, and the protection check.
module mcc_config_control (
  // Clock and reset.
  input  wire                     i_clk_sys,
  input  wire                     i_resetn,
  // Memory request from this processor.
  input  wire                     i_req,
  input  wire                     i_req_wr,
  input  wire [`MCC_ADDR_W-1:0]   i_laddr,
  // Memory module side answer of the addressed module's control.
  input  wire [`MCC_MOD_W-1:0]    i_mem_id,
  input  wire [14:0]              i_isolated,
  // Load operations; four words arrive one per cycle.
  input  wire                     i_load_self,
  input  wire                     i_load_ext,
  input  wire [`MCC_INH_W-1:0]    i_inhibit,
  input  wire [`MCC_SEL_W-1:0]    i_select,
  input  wire                     i_word_vld,
  input  wire [`MCC_ADDR_W-1:0]   i_word,
  // Protection word write.
  input  wire                     i_pw_we,
  input  wire [`MCC_PW_AW-1:0]    i_pw_addr,
  input  wire [`MCC_PW_W-1:0]     i_pw_data,
  // Activity of this and other processors.
  input  wire                     i_op_done,
  input  wire                     i_cycle_end,
  input  wire                     i_other_st3,
  // Translated request outputs.
  output reg  [`MCC_ADDR_W-1:0]   o_paddr,
  output reg                      o_grant,
  output reg                      o_key_violation,
  output reg                      o_invalid,
  // State and control outputs.
  output reg  [`MCC_ADDR_W-1:0]   o_comm_state,
  output reg  [`MCC_MEM_CS_W-1:0] o_mem_comm_state,
  output reg  [`MCC_IOC_CS_W-1:0] o_ioc_comm_state,
  output reg                      o_halted,
  output reg                      o_st3,
  output reg                      o_refetch,
  output reg                      o_ioc_stop,
  output reg                      o_load_err
);
  // ******************************************************
  // Registers
  // ******************************************************
  reg [`MCC_ADDR_W-1:0]   tr_first;      // Entries 1 to 7.
  reg [`MCC_ADDR_W-1:0]   tr_second;     // Entries 8 to 15.
  reg [`MCC_ADDR_W-1:0]   pref_reg;      // Preferential start and key.
  reg [`MCC_ADDR_W-1:0]   comm_state_reg; // 29 enables plus 3 state.
  reg [`MCC_MEM_CS_W-1:0] memory_comm_state_reg;
  reg [`MCC_IOC_CS_W-1:0] io_ctrl_comm_state_reg;
  reg [1:0]               word_idx;      // Which of four words is next.
  reg                     loading;       // A load sequence is active.
  reg                     load_is_ext;   // Current load is external.
  reg [`MCC_INH_W-1:0]    inh;           // Latched inhibit bits.
  reg [`MCC_SEL_W-1:0]    sel;           // Latched target select.
  reg                     pend_req;      // Request awaiting key word.
  reg                     pend_wr;
  reg                     pend_ok;
  reg [`MCC_ADDR_W-1:0]   pend_addr;
  reg                     reloaded;      // Reloaded while halted.
  reg                     pend_halt;     // Halt waits on operation or cycle end.

  // ******************************************************
  // State machine for halting
  // ******************************************************
  localparam RUN  = 3'h1;
  localparam WAIT = 3'h2;
  localparam HALT = 3'h4;
  reg [2:0] hstate;
  reg [2:0] next_hstate;

  wire [`MCC_CS_ST_W-1:0] cur_st = comm_state_reg[`MCC_ADDR_W-1:
                                                  `MCC_CS_ST_LSB];
  wire in_st3 = (cur_st == `MCC_ST3);
  wire in_st1 = (cur_st == `MCC_ST1);

  // ******************************************************
  // Translation and protection
  // ******************************************************
  wire [`MCC_ADDR_W-1:0] tr_paddr;
  wire [`MCC_MOD_W-1:0]  tr_alt;
  wire                   tr_inv;
  wire [`MCC_PW_W-1:0]   pword;

  mcc_translate #(
    .HAS_PSA (1)
  ) u_translate (
    .i_laddr     (i_laddr),
    .i_tr_first  (tr_first),
    .i_tr_second (tr_second),
    .i_psr       (pref_reg),
    .o_paddr     (tr_paddr),
    .o_alt_mod   (tr_alt),
    .o_invalid   (tr_inv)
  );

  // Top offset bits index the protection word.
  mcc_key_store u_keys (
    .i_clk_sys (i_clk_sys),
    .i_we      (i_pw_we),
    .i_waddr   (i_pw_addr),
    .i_wdata   (i_pw_data),
    .i_raddr   (tr_paddr[`MCC_OFS_W-1:`MCC_OFS_W-`MCC_PW_AW]),
    .o_rdata   (pword)
  );

  // Module enable checks, indexed from module 1.
  wire [`MCC_MOD_W-1:0] pmod = tr_paddr[`MCC_MOD_MSB:`MCC_MOD_LSB];
  wire mod_ok  = (pmod != `MCC_MOD_ZERO);
  wire [3:0] pidx = pmod - 4'h1;
  wire own_en  = comm_state_reg[`MCC_CS_MEM_LSB + pidx];
  // Memory side enable of this processor, bit 0 of its field.
  wire mem_en  = memory_comm_state_reg[0];
  // Three-way enable; state 3 overrides all but isolation.
  wire path_ok = mod_ok & (pmod == i_mem_id) & ~tr_inv &
                 (in_st3 ? ~i_isolated[pidx] : (own_en & mem_en));
  // Requester key lives in the preferential register.
  wire [3:0] my_key = pref_reg[`MCC_PSR_KEY_LSB +: 4];
  wire key_miss = (my_key != pword[`MCC_PW_KEY_LSB +: 4]);
  wire viol = key_miss & (pend_wr ? pword[`MCC_PW_WP_BIT]
                                  : pword[`MCC_PW_RP_BIT]);

  // Requests are held one cycle while the protection word is read.
  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      pend_req        <= 1'b0;
      pend_wr         <= 1'b0;
      pend_ok         <= 1'b0;
      pend_addr       <= {`MCC_ADDR_W{1'b0}};
      o_paddr         <= {`MCC_ADDR_W{1'b0}};
      o_grant         <= 1'b0;
      o_key_violation <= 1'b0;
      o_invalid       <= 1'b0;
    end else begin
      pend_req  <= i_req & ~o_halted;
      pend_wr   <= i_req_wr;
      pend_ok   <= path_ok;
      pend_addr <= tr_paddr;
      o_invalid <= i_req & tr_inv;
      o_paddr   <= pend_addr;
      // Protected mismatch gives no grant and a violation.
      o_grant         <= pend_req & pend_ok & ~viol;
      o_key_violation <= pend_req & pend_ok & viol;
    end
  end

  // ******************************************************
  // Load sequencing
  // ******************************************************
  // Self load anytime; external only from state 3.
  wire start_self = i_load_self & ~loading;
  wire start_ext  = i_load_ext & ~loading & in_st3;
  // Selected target: bit 0 memory module, bit 1 controller.
  wire tgt_self   = ~load_is_ext;
  wire tgt_mem    = load_is_ext & sel[0];
  wire tgt_ioc    = load_is_ext & sel[1];
  wire ld_now     = loading & i_word_vld;

  // Self load: four words fill the four registers, each unless inhibited; external load uses only word 3.
  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      loading     <= 1'b0;
      load_is_ext <= 1'b0;
      inh         <= {`MCC_INH_W{1'b0}};
      sel         <= {`MCC_SEL_W{1'b0}};
      word_idx    <= 2'h0;
      o_load_err  <= 1'b0;
      tr_first    <= {`MCC_ADDR_W{1'b0}};
      tr_second   <= {`MCC_ADDR_W{1'b0}};
      pref_reg    <= {`MCC_ADDR_W{1'b0}};
      comm_state_reg         <= {`MCC_ADDR_W{1'b0}};
      memory_comm_state_reg  <= {`MCC_MEM_CS_W{1'b0}};
      io_ctrl_comm_state_reg <= {`MCC_IOC_CS_W{1'b0}};
    end else begin
      o_load_err <= i_load_ext & ~loading & ~in_st3;
      if (start_self) begin
        // Five inhibit bits from the instruction.
        loading     <= 1'b1;
        load_is_ext <= 1'b0;
        inh         <= i_inhibit;
        word_idx    <= 2'h0;
      end else if (start_ext) begin
        // Targets chosen by select bits 0 and 1 of the 22.
        loading     <= 1'b1;
        load_is_ext <= 1'b1;
        inh         <= i_inhibit;
        sel         <= i_select;
        word_idx    <= 2'h0;
      end else if (ld_now) begin
        word_idx <= word_idx + 2'h1;
        if (word_idx == 2'h3) begin
          loading <= 1'b0;
        end
        case (word_idx)
          2'h0: begin
            if (tgt_self && !inh[`MCC_INH_TR1]) begin
              tr_first <= i_word;
            end
          end
          2'h1: begin
            if (tgt_self && !inh[`MCC_INH_TR2]) begin
              tr_second <= i_word;
            end
          end
          2'h2: begin
            if (tgt_self && !inh[`MCC_INH_PSR]) begin
              pref_reg <= i_word;
            end
          end
          default: begin
            // Enable and state parts load separately.
            if (tgt_self && !inh[`MCC_INH_EN]) begin
              comm_state_reg[`MCC_CS_EN_W-1:0] <= i_word[`MCC_CS_EN_W-1:0];
            end
            // Other processors hold us out of state 3.
            if (tgt_self && !inh[`MCC_INH_ST] &&
                !(i_other_st3 &&
                  i_word[`MCC_ADDR_W-1:`MCC_CS_ST_LSB] == `MCC_ST3)) begin
              comm_state_reg[`MCC_ADDR_W-1:`MCC_CS_ST_LSB] <=
                i_word[`MCC_ADDR_W-1:`MCC_CS_ST_LSB];
            end
            // Memory: 7 enables plus 2 state bits.
            if (tgt_mem && !inh[`MCC_INH_EN]) begin
              memory_comm_state_reg[6:0] <= i_word[6:0];
            end
            if (tgt_mem && !inh[`MCC_INH_ST]) begin
              memory_comm_state_reg[8:7] <= i_word[8:7];
            end
            // Controller: 19 enables plus 2 state bits.
            if (tgt_ioc && !inh[`MCC_INH_EN]) begin
              io_ctrl_comm_state_reg[18:0] <= i_word[18:0];
            end
            if (tgt_ioc && !inh[`MCC_INH_ST]) begin
              io_ctrl_comm_state_reg[20:19] <= i_word[20:19];
            end
          end
        endcase
      end
    end
  end

  // ******************************************************
  // Halt control
  // ******************************************************
  always @* begin
    next_hstate = hstate;
    case (hstate)
      RUN: begin
        // Another state 3 stops us at the cycle end.
        if (i_other_st3 && i_cycle_end) begin
          next_hstate = HALT;
        end else if (i_other_st3) begin
          next_hstate = WAIT;
        end else if (in_st1) begin
          // State 1 lets the current operation finish.
          next_hstate = i_op_done ? HALT : WAIT;
        end
      end
      WAIT: begin
        if ((i_other_st3 && i_cycle_end) || (in_st1 && i_op_done)) begin
          next_hstate = HALT;
        end else if (!i_other_st3 && !in_st1) begin
          next_hstate = RUN;
        end
      end
      HALT: begin
        // Release resumes the current microprogram, or refetches after a reload while halted.
        if (!i_other_st3 && !in_st1) begin
          next_hstate = RUN;
        end
      end
      default: begin
        next_hstate = RUN;
      end
    endcase
  end

  // Halt register, refetch marker and controller stop.
  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      hstate       <= RUN;
      reloaded     <= 1'b0;
      pend_halt    <= 1'b0;
      o_halted     <= 1'b0;
      o_st3        <= 1'b0;
      o_refetch    <= 1'b0;
      o_ioc_stop   <= 1'b0;
      o_comm_state <= {`MCC_ADDR_W{1'b0}};
      o_mem_comm_state <= {`MCC_MEM_CS_W{1'b0}};
      o_ioc_comm_state <= {`MCC_IOC_CS_W{1'b0}};
    end else begin
      hstate    <= next_hstate;
      pend_halt <= (next_hstate == WAIT);
      o_halted  <= (next_hstate == HALT);
      o_st3     <= in_st3;
      // Controllers stop at once on any state 3.
      o_ioc_stop <= in_st3 | i_other_st3;
      // A reload while halted forces a fresh fetch on release.
      if (hstate == HALT && ld_now) begin
        reloaded <= 1'b1;
      end else if (hstate != HALT) begin
        reloaded <= 1'b0;
      end
      o_refetch <= (hstate == HALT) && (next_hstate == RUN) &&
                   (reloaded | (ld_now & ~load_is_ext));
      o_comm_state     <= comm_state_reg;
      o_mem_comm_state <= memory_comm_state_reg;
      o_ioc_comm_state <= io_ctrl_comm_state_reg;
    end
  end
endmodule

// ==== tb/mcc_checker_sva.sv ====
`timescale 1ns/100ps
`include "mcc_map.vh"
// ****************************************************************
// Port checker for one processor's configuration control.
// ****************************************************************
module mcc_checker (
  // Clock and reset.
  input wire                   i_clk_sys,
  input wire                   i_resetn,
  // Stimulus watched.
  input wire                   i_req,
  input wire                   i_load_ext,
  input wire                   i_cycle_end,
  input wire                   i_other_st3,
  // Results watched.
  input wire [`MCC_ADDR_W-1:0] o_paddr,
  input wire                   o_grant,
  input wire                   o_key_violation,
  input wire                   o_invalid,
  input wire [`MCC_ADDR_W-1:0] o_comm_state,
  input wire                   o_halted,
  input wire                   o_st3,
  input wire                   o_ioc_stop,
  input wire                   o_load_err
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);
  // A request only counts while this processor runs.
  sequence req_taken;
    i_req && !o_halted;
  endsequence
  // Another processor holds state 3 over one of our cycle ends.
  sequence other_hold;
    (i_other_st3 && i_cycle_end) ##1 i_other_st3 [*2];
  endsequence
  // Some processor, this one or another, sits in state 3.
  sequence any_st3;
    (i_other_st3 || o_st3) [*3];
  endsequence
  chk_grant_cause: assert property (
    o_grant |-> $past(i_req && !o_halted, 2))
    else $error("grant without a taken request");
  chk_viol_cause: assert property (
    o_key_violation |-> $past(i_req && !o_halted, 2))
    else $error("violation without a taken request");
  chk_grant_excl: assert property (
    !(o_grant && o_key_violation))
    else $error("grant and violation together");
  chk_invalid_quiet: assert property (
    req_taken ##1 o_invalid |=> !o_grant && !o_key_violation)
    else $error("invalid reference still answered");
  chk_grant_module: assert property (
    o_grant |-> o_paddr[31:18] == 14'h0 && o_paddr[17:14] != 4'h0)
    else $error("granted address outside module range");
  chk_state_code: assert property (
    o_comm_state[31:29] inside {3'h0, 3'h1, 3'h2, 3'h6})
    else $error("illegal state code");
  chk_halt_refuse: assert property (
    o_halted [*3] |-> !o_grant && !o_key_violation)
    else $error("halted processor answered a request");
  chk_other_halts: assert property (
    other_hold |-> o_halted && !o_st3)
    else $error("no halt under another state 3");
  chk_ioc_stops: assert property (
    any_st3 |-> o_ioc_stop)
    else $error("controllers not stopped in state 3");
  chk_load_err: assert property (
    o_load_err |-> $past(i_load_ext) && !$past(o_st3))
    else $error("load error without a refused load");
endmodule
bind mcc_config_control mcc_checker chk_i (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_req(i_req),
  .i_load_ext(i_load_ext), .i_cycle_end(i_cycle_end),
  .i_other_st3(i_other_st3), .o_paddr(o_paddr), .o_grant(o_grant),
  .o_key_violation(o_key_violation), .o_invalid(o_invalid),
  .o_comm_state(o_comm_state), .o_halted(o_halted), .o_st3(o_st3),
  .o_ioc_stop(o_ioc_stop), .o_load_err(o_load_err));

// ==== tb/mcc_far_model.sv ====
`timescale 1ns/100ps
// ****************************************************************
// Memory module answering with its physical identity.
// ****************************************************************
module mcc_far_model (
  // Clock.
  input wire        i_clk_sys,
  // Addressed module, wrong-answer command and select.
  input wire [3:0]  i_id,
  input wire        i_bad,
  input wire        i_sel,
  // Identity seen by the requester.
  output reg  [3:0] o_mem_id
);
  // An unselected bus keeps counting through all ids, so a stale id does not hold still.
  always @(posedge i_clk_sys) begin
    if (!i_sel) begin
      o_mem_id <= o_mem_id + 4'h1;
    end else begin
      o_mem_id <= i_bad ? ~i_id : i_id;
    end
  end
endmodule

// ==== tb/mcc_config_control_bench.sv ====
`timescale 1ns/100ps
`include "mcc_map.vh"
// ****************************************************************
// Self-checking bench with a reference model of the control unit.
// ****************************************************************
module mcc_config_control_bench;
  reg         clk, rstn, req, wr, lself, lext, wv, pwe, opd, cye, oth;
  reg  [31:0] la, wd, seed, pref, csm, a;
  reg  [14:0] iso;
  reg  [4:0]  inh, pa;
  reg  [21:0] sel;
  reg  [5:0]  pd;
  reg  [3:0]  fid;
  reg         fbad, fsel, st3m, hltm, lerr_seen, mme;
  wire [3:0]  mid;
  wire [31:0] pad, cs;
  wire [8:0]  mcs;
  wire [20:0] ics;
  wire        gnt, kv, inv, hlt, st3, rf, ist, lerr;
  reg  [3:0]  tr [0:15];  // Model translation table.
  reg  [5:0]  pw [0:31];  // Model protection words.
  reg  [31:0] w [0:3];    // Words of the next load.
  reg  [5:0]  pt [0:3];   // Protection cases.
  integer     err_total, check_count, cyc, k, j;

  mcc_config_control dut (.i_clk_sys(clk), .i_resetn(rstn), .i_req(req),
    .i_req_wr(wr), .i_laddr(la), .i_mem_id(mid), .i_isolated(iso),
    .i_load_self(lself), .i_load_ext(lext), .i_inhibit(inh),
    .i_select(sel), .i_word_vld(wv), .i_word(wd), .i_pw_we(pwe),
    .i_pw_addr(pa), .i_pw_data(pd), .i_op_done(opd), .i_cycle_end(cye),
    .i_other_st3(oth), .o_paddr(pad), .o_grant(gnt),
    .o_key_violation(kv), .o_invalid(inv), .o_comm_state(cs),
    .o_mem_comm_state(mcs), .o_ioc_comm_state(ics), .o_halted(hlt),
    .o_st3(st3), .o_refetch(rf), .o_ioc_stop(ist), .o_load_err(lerr));
  mcc_far_model far (.i_clk_sys(clk), .i_id(fid), .i_bad(fbad),
    .i_sel(fsel), .o_mem_id(mid));

  // 20 MHz clock.
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  // Cuts a hang short; the whole run needs well under 2000 cycles.
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 4000) begin
      err_total = err_total + 1;
      tally_and_finish;
    end
  end

  // Counts one comparison and reports a mismatch.
  task chk(input string n, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        $display("unexpected %s: expected %h seen %h", n, e, g);
        err_total = err_total + 1;
      end
    end
  endtask

  // Start pulse, then the four words one per cycle, then settling.
  task ld(input s, input [4:0] n, input [21:0] c);
    begin
      @(negedge clk);
      lself = s;
      lext = !s;
      inh = n;
      sel = c;
      @(negedge clk);
      lself = 0;
      lext = 0;
      lerr_seen = lerr;
      for (j = 0; j < 4; j = j + 1) begin
        wv = 1;
        wd = w[j];
        @(negedge clk);
        lerr_seen = lerr_seen | lerr;
      end
      wv = 0;
      repeat (3) @(negedge clk);
    end
  endtask

  // One request, checked against the model at each answer.
  task rq(input [31:0] ad, input wv_, input bad);
    reg [31:0] p;
    reg [5:0]  q;
    integer    x;
    begin
      p = {14'h0, tr[ad[17:14]], ad[13:0]};
      if (ad[17:14] == 4'h0) p = {14'h0, pref[3:0], pref[12:8], ad[8:0]};
      q = pw[p[13:9]];
      x = (wv_ ? q[4] : q[5]) && q[3:0] != pref[19:16];
      if (bad || hltm || st3m && iso[p[17:14] - 1]) x = 3;
      if (!st3m && !(csm[p[17:14] - 1] && mme)) x = 3;
      if (ad[17:14] == 4'h0 && ad[13:9] != 5'h0) x = 2;
      fid = p[17:14];
      fbad = bad;
      fsel = 1;
      @(negedge clk);
      req = 1;
      la = ad;
      wr = wv_;
      @(negedge clk);
      req = 0;
      chk("invalid", x == 2, inv);
      @(negedge clk);
      chk("grant", x == 0, gnt);
      chk("violation", x == 1, kv);
      if (x == 0) chk("paddr", p, pad);
      fsel = 0;
      @(negedge clk);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask

  // Main sequence.
  initial begin
    {req, wr, lself, lext, wv, pwe, opd, cye, oth, fbad, fsel} = 0;
    {la, wd, inh, sel, pa, pd, fid, iso, st3m, hltm} = 0;
    {err_total, check_count, cyc} = 0;
    seed = 32'hC3DA5031;
    rstn = 0;
    repeat (10) @(negedge clk);
    rstn = 1;
    chk("reset state", 0, {st3, hlt, cs[31:2]});
    pwe = 1;
    for (k = 0; k < 32; k = k + 1) begin
      pa = k;
      pd = 6'h00;
      pw[k] = 6'h00;
      @(negedge clk);
    end
    pwe = 0;
    for (k = 0; k < 4; k = k + 1) w[k] = 0;
    ld(0, 5'h00, 22'h1);
    chk("refused load", 1, lerr_seen);
    chk("memory reg", 0, mcs);
    $display("test refused load finished");
    for (k = 1; k < 16; k = k + 1) begin
      tr[k] = 1 + {$random(seed)} % 15;
      if (k < 8) w[0][4*(k-1) +: 4] = tr[k];
      else w[1][4*(k-8) +: 4] = tr[k];
    end
    pref = 32'h000A0005 | (({$random(seed)} & 32'h1F) << 8);
    w[2] = pref;
    csm = 32'hDFFFFFFF;
    w[3] = csm;
    ld(1, 5'h00, 22'h0);
    st3m = 1;
    chk("comm state", csm, cs);
    chk("state 3", 1, st3);
    chk("ioc stop", 1, ist);
    w[3] = 32'h17F;
    ld(0, 5'h00, 22'h1);
    chk("memory reg", 9'h17F, mcs);
    mme = 1;
    w[3] = 32'h17FFFF;
    ld(0, 5'h00, 22'h2);
    chk("ioc reg", 21'h17FFFF, ics);
    iso = 15'h1 << (tr[3] - 1);
    rq(32'h0000C123, 0, 0);
    rq(32'h00010123, 1, 0);
    iso = 0;
    $display("test state 3 finished");
    for (k = 0; k < 3; k = k + 1) w[k] = 0;
    csm = 32'h5FFFFFFF;
    w[3] = csm;
    ld(1, 5'h07, 22'h0);
    st3m = 0;
    chk("state 3 left", 0, st3);
    chk("comm state", csm, cs);
    for (k = 0; k < 16; k = k + 1) begin
      a = {$random(seed)} & 32'h3FFFF;
      rq(a, $random(seed) & 1, 0);
      rq({$random(seed)} & 32'h1FF, 0, 0);
    end
    rq(32'h00000200, 0, 0);
    $display("test translation finished");
    pt[0] = 6'h23;
    pt[1] = 6'h23;
    pt[2] = 6'h13;
    pt[3] = 6'h2A;
    for (k = 0; k < 4; k = k + 1) begin
      @(negedge clk);
      pwe = 1;
      pa = 5'h05;
      pd = pt[k];
      pw[5] = pt[k];
      @(negedge clk);
      pwe = 0;
      rq(32'h00004A00, k == 1 || k == 2, 0);
    end
    rq(32'h00004A00, 0, 1);
    csm = 32'h5FFFFFFF & ~(32'h1 << (tr[1] - 1));
    w[3] = csm;
    ld(1, 5'h0F, 22'h0);
    rq(32'h00004A00, 0, 0);
    $display("test protection finished");
    oth = 1;
    @(negedge clk);
    cye = 1;
    @(negedge clk);
    cye = 0;
    repeat (2) @(negedge clk);
    hltm = 1;
    chk("halted", 1, hlt);
    rq(32'h00008000, 0, 0);
    w[3] = 32'hDFFFFFFF;
    ld(1, 5'h17, 22'h0);
    chk("state 3 blocked", 0, st3);
    oth = 0;
    @(negedge clk);
    chk("refetch", 1, rf);
    repeat (2) @(negedge clk);
    hltm = 0;
    chk("resumed", 0, hlt);
    w[3] = 32'h20000000;
    ld(1, 5'h17, 22'h0);
    opd = 1;
    @(negedge clk);
    opd = 0;
    repeat (2) @(negedge clk);
    hltm = 1;
    chk("state 1 halt", 1, hlt);
    rq(32'h00008000, 0, 0);
    $display("test halting finished");
    tally_and_finish;
  end
endmodule
